// file: core/sbsc_consts.svh
`ifndef SBSC_CONSTS_SVH
`define SBSC_CONSTS_SVH

// Widths of the address and data paths
`define SBSC_ADDR_W 19
`define SBSC_DATA_W 18
`define SBSC_BURST_W 2

// Clock and sleep recovery timing
`define SBSC_CLK_PERIOD_NS 20
`define SBSC_SLEEP_RECOVERY_NS 20
// Least time, so round up to whole cycles, never below one
`define SBSC_RECOVERY_CYCLES \
  (((`SBSC_SLEEP_RECOVERY_NS + `SBSC_CLK_PERIOD_NS - 1) / \
    `SBSC_CLK_PERIOD_NS) < 1 ? 1 : \
   ((`SBSC_SLEEP_RECOVERY_NS + `SBSC_CLK_PERIOD_NS - 1) / \
    `SBSC_CLK_PERIOD_NS))
`define SBSC_REC_CNT_W 4

// Values the pin stages hold after reset, matching the pad pulls
`define SBSC_FT_PULL 1'b1
`define SBSC_SLEEP_PULL 1'b0
`define SBSC_LBO_RESET 1'b1

// Burst step that opens a burst
`define SBSC_STEP_FIRST 2'h0
`define SBSC_STEP_ONE 2'h1
`define SBSC_LOW_MSB 1
`define SBSC_LOW_LSB 0

`endif

// file: core/sbsc_pkg.sv
package sbsc_pkg;

  // Power state of the device
  typedef enum logic [1:0] {
    SBSC_ACTIVE  = 2'b00,
    SBSC_ASLEEP  = 2'b01,
    SBSC_RECOVER = 2'b10
  } sbsc_state_t;

  // Operation carried by continue cycles
  typedef enum logic [1:0] {
    SBSC_OP_DESEL = 2'b00,
    SBSC_OP_READ  = 2'b01,
    SBSC_OP_WRITE = 2'b10
  } sbsc_op_t;

endpackage

// file: core/sbsc_burst_if.sv
`include "sbsc_consts.svh"
`timescale 1ns/10ps
`default_nettype none

interface sbsc_burst_if;
  logic load;
  logic advance;
  logic interleaved;
  logic [`SBSC_ADDR_W-1:0] start_addr;
  logic [`SBSC_ADDR_W-1:0] addr;

  modport ctl (
    output load,
    output advance,
    output interleaved,
    output start_addr,
    input addr
  );

  modport ctr (
    input load,
    input advance,
    input interleaved,
    input start_addr,
    output addr
  );
endinterface

`default_nettype wire

// file: core/sbsc_burst_ctr.sv
`include "sbsc_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module sbsc_burst_ctr (
  input wire logic clk_sys,
  input wire logic srst,
  sbsc_burst_if.ctr bus
);

  logic [`SBSC_ADDR_W-1:0] base;
  logic [`SBSC_BURST_W-1:0] step;
  logic [`SBSC_ADDR_W-1:0] next_base;
  logic [`SBSC_BURST_W-1:0] next_step;
  logic [`SBSC_BURST_W-1:0] low;

  // Load takes the whole address; continue only moves the step
  always_comb begin
    next_base = base;
    next_step = step;
    if (bus.load) begin
      next_base = bus.start_addr;
      next_step = `SBSC_STEP_FIRST;
    end else if (bus.advance) begin
      next_step = step + `SBSC_STEP_ONE; // RULE_02
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      base <= '0;
      step <= `SBSC_STEP_FIRST;
    end else begin
      base <= next_base;
      step <= next_step;
    end
  end

  // Address after this edge, so a continue uses its new step; the step
  // wraps at four, so the fourth continue returns to the start
  always_comb begin
    if (bus.interleaved) begin
      low = next_base[`SBSC_LOW_MSB:`SBSC_LOW_LSB] ^ next_step; // RULE_01
    end else begin
      low = next_base[`SBSC_LOW_MSB:`SBSC_LOW_LSB] + next_step; // RULE_03
    end
  end

  // Upper bits stay as loaded
  assign bus.addr = {next_base[`SBSC_ADDR_W-1:`SBSC_BURST_W], low}; // RULE_04

endmodule // sbsc_burst_ctr

`default_nettype wire

// file: core/sbsc_core.sv
// Contract
// RULE_01: Interleaved order: start low bits XOR step.
// RULE_02: Burst counter wraps to start after four.
// RULE_03: Order pin low linear, high interleaved.
// RULE_04: Counter moves only two low address bits.
// RULE_05: Controller holds sleep request low normally.
// RULE_06: Sleep entered two clock cycles after request.
// RULE_07: All internal state kept while asleep.
// RULE_08: Asleep: deselected, inputs ignored, outputs high-Z.
// RULE_09: Sleep lasts exactly while request stays high.
// RULE_10: Normal operation resumes after recovery interval.
// RULE_11: Controller finishes accesses before requesting sleep.
// RULE_12: Only deselect or read during recovery.
// RULE_13: Strap selects flow-through or pipelined output.
// RULE_14: Open strap means pipelined; open sleep active.
// RULE_15: Entry delay counted from first high sample.
`include "sbsc_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module sbsc_core (
  input wire logic clk_sys,
  input wire logic srst,
  // Asynchronous pins
  input wire logic sleep_request,
  input wire logic flow_through_select_n,
  input wire logic linear_burst_order_select_n,
  // Synchronous command pins from the controller
  input wire logic clock_enable_n,
  input wire logic chip_enable,
  input wire logic burst_advance,
  input wire logic write_n,
  input wire logic [`SBSC_ADDR_W-1:0] addr,
  // Array port
  output logic [`SBSC_ADDR_W-1:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  input wire logic [`SBSC_DATA_W-1:0] mem_rd_data,
  // Data pins, output half only
  output logic [`SBSC_DATA_W-1:0] dq_out,
  output logic dq_oe_n,
  // Status
  output logic sleep_active,
  output logic sleep_recovering
);

  sbsc_burst_if burst ();

  // Pin synchronisers
  logic sleep_meta;
  logic sleep_sync;
  logic ft_meta;
  logic ft_sync;
  logic lbo_meta;
  logic lbo_sync;

  // Power state
  sbsc_pkg::sbsc_state_t state;
  sbsc_pkg::sbsc_state_t next_state;
  logic [`SBSC_REC_CNT_W-1:0] rec_cnt;
  logic [`SBSC_REC_CNT_W-1:0] next_rec_cnt;

  // Command state
  sbsc_pkg::sbsc_op_t op;
  sbsc_pkg::sbsc_op_t next_op;
  logic next_mem_rd;
  logic next_mem_wr;
  logic [`SBSC_ADDR_W-1:0] next_mem_addr;
  logic take_cmd;
  logic writes_ok;

  // Read data path
  logic [`SBSC_DATA_W-1:0] pipe_data;
  logic pipe_valid;
  logic dq_drive;
  logic [`SBSC_DATA_W-1:0] next_pipe_data;
  logic next_pipe_valid;
  logic [`SBSC_DATA_W-1:0] next_dq_out;
  logic next_dq_drive;

  // Two flops per pin; reset values match the pad pulls
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sleep_meta <= `SBSC_SLEEP_PULL; // RULE_14
      sleep_sync <= `SBSC_SLEEP_PULL;
      ft_meta <= `SBSC_FT_PULL; // RULE_14
      ft_sync <= `SBSC_FT_PULL;
      lbo_meta <= `SBSC_LBO_RESET;
      lbo_sync <= `SBSC_LBO_RESET;
    end else begin
      sleep_meta <= sleep_request;
      sleep_sync <= sleep_meta; // RULE_15
      ft_meta <= flow_through_select_n;
      ft_sync <= ft_meta;
      lbo_meta <= linear_burst_order_select_n;
      lbo_sync <= lbo_meta;
    end
  end

  // The two synchroniser stages are the two-cycle entry delay, so
  // no separate counter is needed and the pin is never read raw
  always_comb begin
    next_state = state;
    next_rec_cnt = rec_cnt;
    case (state)
      sbsc_pkg::SBSC_ACTIVE: begin
        if (sleep_sync) begin
          next_state = sbsc_pkg::SBSC_ASLEEP; // RULE_06
        end
      end
      sbsc_pkg::SBSC_ASLEEP: begin
        if (!sleep_sync) begin
          next_state = sbsc_pkg::SBSC_RECOVER; // RULE_09
          next_rec_cnt = '0;
        end
      end
      sbsc_pkg::SBSC_RECOVER: begin
        if (sleep_sync) begin
          next_state = sbsc_pkg::SBSC_ASLEEP;
        end else if (rec_cnt ==
                     `SBSC_REC_CNT_W'(`SBSC_RECOVERY_CYCLES - 1)) begin
          next_state = sbsc_pkg::SBSC_ACTIVE; // RULE_10
        end else begin
          next_rec_cnt = rec_cnt + `SBSC_REC_CNT_W'(1);
        end
      end
      default: begin
        next_state = sbsc_pkg::SBSC_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= sbsc_pkg::SBSC_ACTIVE;
      rec_cnt <= '0;
    end else begin
      state <= next_state;
      rec_cnt <= next_rec_cnt;
    end
  end

  // Commands are taken only while awake and not stalled
  assign take_cmd = (state != sbsc_pkg::SBSC_ASLEEP) && !sleep_sync &&
                    !clock_enable_n; // RULE_08
  // Writes during recovery are dropped as a guard against a bad host
  assign writes_ok = (state == sbsc_pkg::SBSC_ACTIVE); // RULE_12

  assign burst.load = take_cmd && !burst_advance && chip_enable;
  assign burst.advance = take_cmd && burst_advance &&
                         (op != sbsc_pkg::SBSC_OP_DESEL);
  assign burst.interleaved = lbo_sync; // RULE_03
  assign burst.start_addr = addr;

  sbsc_burst_ctr u_burst_ctr (
    .clk_sys(clk_sys),
    .srst(srst),
    .bus(burst.ctr)
  );

  // Decode the command; continue cycles repeat the last operation
  always_comb begin
    next_op = op;
    next_mem_rd = 1'b0;
    next_mem_wr = 1'b0;
    next_mem_addr = mem_addr;
    if (take_cmd) begin
      if (!burst_advance) begin
        if (!chip_enable) begin
          next_op = sbsc_pkg::SBSC_OP_DESEL;
        end else if (!write_n) begin
          next_op = sbsc_pkg::SBSC_OP_WRITE;
          next_mem_addr = addr;
          next_mem_wr = writes_ok;
        end else begin
          next_op = sbsc_pkg::SBSC_OP_READ;
          next_mem_addr = addr;
          next_mem_rd = 1'b1;
        end
      end else if (op != sbsc_pkg::SBSC_OP_DESEL) begin
        // Counter address after this advance
        next_mem_addr = {mem_addr[`SBSC_ADDR_W-1:`SBSC_BURST_W],
                         burst.addr[`SBSC_LOW_MSB:`SBSC_LOW_LSB]};
        next_mem_rd = (op == sbsc_pkg::SBSC_OP_READ);
        next_mem_wr = (op == sbsc_pkg::SBSC_OP_WRITE) && writes_ok;
      end
    end
  end

  // Registers hold their values while asleep; only the mem_rd and mem_wr strobes clear
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      op <= sbsc_pkg::SBSC_OP_DESEL;
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      mem_addr <= '0;
    end else begin
      op <= next_op; // RULE_07
      mem_rd <= next_mem_rd;
      mem_wr <= next_mem_wr;
      mem_addr <= next_mem_addr;
    end
  end

  // Read data: flow-through drives the array word one edge after the
  // strobe, pipelined holds it in one more register first
  always_comb begin
    next_pipe_data = pipe_data;
    next_pipe_valid = pipe_valid;
    next_dq_out = dq_out;
    next_dq_drive = dq_drive;
    if (state != sbsc_pkg::SBSC_ASLEEP) begin
      next_pipe_data = mem_rd_data;
      next_pipe_valid = mem_rd;
      if (!ft_sync) begin
        next_dq_out = mem_rd_data; // RULE_13
        next_dq_drive = mem_rd;
      end else begin
        next_dq_out = pipe_data; // RULE_13
        next_dq_drive = pipe_valid;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pipe_data <= '0;
      pipe_valid <= 1'b0;
      dq_out <= '0;
      dq_drive <= 1'b0;
    end else begin
      pipe_data <= next_pipe_data; // RULE_07
      pipe_valid <= next_pipe_valid;
      dq_out <= next_dq_out;
      dq_drive <= next_dq_drive;
    end
  end

  // Bus released at once in sleep, drive state restored on wake
  assign dq_oe_n = !dq_drive || (state == sbsc_pkg::SBSC_ASLEEP); // RULE_08
  assign sleep_active = (state == sbsc_pkg::SBSC_ASLEEP);
  assign sleep_recovering = (state == sbsc_pkg::SBSC_RECOVER);

endmodule // sbsc_core

`default_nettype wire

// file: tb/sbsc_array_model.sv
`include "sbsc_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module sbsc_array_model (
  input wire logic clk_sys,
  input wire logic mem_rd,
  input wire logic [`SBSC_ADDR_W-1:0] mem_addr,
  output logic [`SBSC_DATA_W-1:0] mem_rd_data
);
  logic tog = 1'b0;
  // Outside read cycles the bus toggles, so stale data never matches
  always @(posedge clk_sys) tog <= ~tog;
  assign mem_rd_data = mem_rd ? mem_addr[17:0] ^ 18'h0a5a5 : {18{tog}};
endmodule // sbsc_array_model

`default_nettype wire

// file: tb/sbsc_core_sva.sv
`include "sbsc_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module sbsc_core_sva (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic sleep_request,
  input wire logic clock_enable_n,
  input wire logic chip_enable,
  input wire logic burst_advance,
  input wire logic [`SBSC_ADDR_W-1:0] addr,
  input wire logic [`SBSC_ADDR_W-1:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic dq_oe_n,
  input wire logic sleep_active,
  input wire logic sleep_recovering
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // Awake with no request: commands are taken
  logic quiet;
  assign quiet = !sleep_request && !sleep_active && !sleep_recovering;

  AST_OE_SLEEP: assert property (sleep_active |-> dq_oe_n)
    else $error("data pins driven while asleep");
  AST_NO_WR: assert property (sleep_active |-> ##2 !mem_wr)
    else $error("write done from a command given asleep");
  AST_ENTRY: assert property (
    $rose(sleep_request) ##1 sleep_request[*2]
    |-> !sleep_active ##1 sleep_active)
    else $error("sleep entry not two cycles after request");
  AST_HOLD: assert property (
    sleep_active && $past(sleep_request, 2) |=> sleep_active)
    else $error("woke while request high");
  AST_EXIT: assert property (
    sleep_active && $fell(sleep_request)
    |-> ##1 sleep_active[*2] ##1 sleep_recovering ##1 quiet)
    else $error("wake sequence wrong");
  AST_REC_WR: assert property (sleep_recovering |=> !mem_wr)
    else $error("write accepted in recovery");
  AST_LOAD: assert property (
    quiet && $past(quiet) && !clock_enable_n && chip_enable && !burst_advance
    |=> (mem_rd ^ mem_wr) && mem_addr == $past(addr))
    else $error("load did not access its address");
  AST_UPPER: assert property (
    quiet && !clock_enable_n && burst_advance ##1
    quiet && !clock_enable_n && burst_advance && mem_rd
    |=> mem_rd && mem_addr[18:2] == $past(mem_addr[18:2]))
    else $error("continue changed upper address bits");
endmodule // sbsc_core_sva

bind sbsc_core sbsc_core_sva u_sva (.clk_sys, .srst, .sleep_request,
  .clock_enable_n, .chip_enable, .burst_advance, .addr, .mem_addr,
  .mem_rd, .mem_wr, .dq_oe_n, .sleep_active, .sleep_recovering);

`default_nettype wire

// file: tb/tb_sbsc_core.sv
`include "sbsc_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module tb_sbsc_core;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic sleep_request = 1'b0;
  logic flow_through_select_n = 1'b1;
  logic linear_burst_order_select_n = 1'b1;
  logic clock_enable_n = 1'b0;
  logic chip_enable = 1'b0;
  logic burst_advance = 1'b0;
  logic write_n = 1'b1;
  logic [`SBSC_ADDR_W-1:0] addr = 19'h0;
  logic [`SBSC_ADDR_W-1:0] mem_addr;
  logic [`SBSC_DATA_W-1:0] mem_rd_data, dq_out;
  logic mem_rd, mem_wr, dq_oe_n, sleep_active, sleep_recovering;
  int n_errors = 0;
  int checked = 0;

  // 50 MHz system clock
  always #10 clk_sys = ~clk_sys;

  sbsc_core dut (.clk_sys, .srst, .sleep_request, .flow_through_select_n,
    .linear_burst_order_select_n, .clock_enable_n, .chip_enable,
    .burst_advance, .write_n, .addr, .mem_addr, .mem_rd, .mem_wr,
    .mem_rd_data, .dq_out, .dq_oe_n, .sleep_active, .sleep_recovering);
  sbsc_array_model arr (.clk_sys, .mem_rd, .mem_addr, .mem_rd_data);

  task automatic chk(input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  // One command just after the edge, held for one clock
  task automatic cyc(input logic ce, adv, wn, input logic [18:0] a);
    chip_enable = ce;
    burst_advance = adv;
    write_n = wn;
    addr = a;
    @(posedge clk_sys);
    #1;
  endtask

  // Single read, then deselects; data may show only at the mode latency
  task automatic rd(input int lat);
    cyc(1'b1, 1'b0, 1'b1, 19'h00123);
    for (int i = 1; i < 5; i++) begin
      cyc(1'b0, 1'b0, 1'b1, 19'h0);
      chk(dq_oe_n, i != lat);
      if (i == lat) chk(dq_out, 18'h00123 ^ 18'h0a5a5);
    end
  endtask

  // Load then six continues; the fourth continue returns to the start
  task automatic burst(input logic lin, input logic [1:0] s);
    logic [1:0] lo;
    cyc(1'b1, 1'b0, 1'b1, {17'h1abcd, s});
    chk(mem_addr, {17'h1abcd, s});
    for (int k = 1; k < 7; k++) begin
      cyc(1'b1, 1'b1, 1'b1, 19'h0);
      lo = lin ? s + k[1:0] : s ^ k[1:0];
      chk(mem_rd, 1'b1);
      chk(mem_addr, {17'h1abcd, lo});
    end
  endtask

  // Stall mid-burst, sleep, try writes, wake, and carry on the burst
  task automatic nap;
    cyc(1'b1, 1'b0, 1'b1, 19'h00155);
    cyc(1'b1, 1'b1, 1'b1, 19'h0);
    clock_enable_n = 1'b1;
    sleep_request = 1'b1;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      #1;
      chk(sleep_active, i == 2);
    end
    clock_enable_n = 1'b0;
    cyc(1'b1, 1'b0, 1'b0, 19'h7ffff);
    cyc(1'b1, 1'b0, 1'b0, 19'h7ffff);
    chk(mem_wr, 1'b0);
    chk(dq_oe_n, 1'b1);
    clock_enable_n = 1'b1;
    sleep_request = 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      #1;
      chk(sleep_recovering, i == 2);
      chk(sleep_active, i < 2);
    end
    clock_enable_n = 1'b0;
    cyc(1'b1, 1'b1, 1'b1, 19'h0);
    chk(mem_addr, 19'h00157);
    cyc(1'b1, 1'b1, 1'b1, 19'h0);
    chk(mem_addr, 19'h00156);
    // Awake again, so a write must now reach the array
    cyc(1'b1, 1'b0, 1'b0, 19'h00200);
    chk(mem_wr, 1'b1);
    chk(mem_addr, 19'h00200);
  endtask

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Default straps first, then linear order with flow-through output
  initial begin
    repeat (10) @(posedge clk_sys);
    #1;
    srst = 1'b0;
    repeat (3) cyc(1'b0, 1'b0, 1'b1, 19'h0);
    rd(2);
    burst(1'b0, 2'h3);
    burst(1'b0, 2'h1);
    nap();
    linear_burst_order_select_n = 1'b0;
    flow_through_select_n = 1'b0;
    repeat (3) cyc(1'b0, 1'b0, 1'b1, 19'h0);
    rd(1);
    burst(1'b1, 2'h2);
    end_of_test();
  end
endmodule // tb_sbsc_core

`default_nettype wire
